// >>> hw/tbc_edge.sv
module tbc_edge (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic own_i,
  input wire logic add_i,
  input wire logic add_en_i,
  input wire logic [1:0] edge_sel_i,
  output logic hit_o
);
  logic own_ff;
  logic add_ff;

  function automatic logic is_edge(input logic cur, input logic prev, input logic [1:0] sel);
    case (sel)
      tbc_pkg::EDGE_RISE: is_edge = cur & ~prev;
      tbc_pkg::EDGE_FALL: is_edge = ~cur & prev;
      default: is_edge = cur ^ prev;
    endcase
  endfunction

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      own_ff <= 1'b0;
      add_ff <= 1'b0;
    end else if (ce_i) begin
      own_ff <= own_i;
      add_ff <= add_i;
    end
  end

  // both pins judged by the channel's own edge selection
  assign hit_o = is_edge(own_i, own_ff, edge_sel_i) |
                 (add_en_i & is_edge(add_i, add_ff, edge_sel_i)); // RULE12
endmodule

// >>> hw/tbc_pin_if.sv
interface tbc_pin_if;
  logic load;
  logic init;
  logic hit;
  logic [1:0] act;
  logic level;
  modport drv (output load, output init, output hit, output act, input level);
  modport pin (input load, input init, input hit, input act, output level);
endinterface

// >>> hw/tbc_pin_out.sv
module tbc_pin_out (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  tbc_pin_if.pin p
);
  logic level_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      level_ff <= 1'b0;
    end else if (ce_i) begin
      if (p.load) begin
        level_ff <= p.init;
      end else if (p.hit) begin
        case (p.act) // RULE14
          tbc_pkg::ACT_LOW: level_ff <= 1'b0;
          tbc_pkg::ACT_HIGH: level_ff <= 1'b1;
          tbc_pkg::ACT_TOG: level_ff <= ~level_ff;
          default: level_ff <= level_ff;
        endcase
      end
    end
  end

  assign p.level = level_ff;
endmodule

// >>> hw/tbc_pkg.sv
// Functional notes
// (RULE1) buffered capture pushes old A into C
// (RULE2) timing select: ch0 pwm1/2, ch3-4 pwm1
// (RULE3) choices: match (reset default) or clearing
// (RULE4) wrap, zero write, clear source all count
// (RULE5) software changes timing select only when stopped
// (RULE6) select bit 0 match, 1 clearing
// (RULE7) ch1 upper, ch2 lower, one 32-bit counter
// (RULE8) cascaded ch1 follows ch2 overflow and underflow
// (RULE9) lower half underflows only in phase mode
// (RULE10) ch1 phase mode overrides cascade selection
// (RULE11) four enables add the partner channel pin
// (RULE12) own and added pin ORed, own edge
// (RULE13) internal capture source ignores added pin
// (RULE14) compare match drives pin low, high, toggle
// (RULE15) clear source register sets the period
// (RULE16) pwm1 pairs A with B, C with D
// (RULE17) pwm1 initial level from A or C
// (RULE18) pwm1 equal pair values leave pin unchanged
// (RULE19) pwm1 gives eight outputs on A/C pins
// (RULE20) pwm2 one cycle register, others duty
// (RULE21) pwm2 cycle clear restores initial levels
// (RULE22) pwm2 duty equal cycle leaves pin unchanged
// (RULE23) no pwm2 on ch3-4, period pin silent
// (RULE24) pwm2 with sync gives seven outputs
package tbc_pkg;
  localparam int NUM_CH = 5;
  localparam int NUM_REG = 4;
  localparam int PIN_PER_CH = 4;
  localparam int NUM_PIN = 20;
  // per channel window: channel in adr[7:5], register in adr[4:0]
  localparam logic [4:0] OFF_CTL = 5'h00;
  localparam logic [4:0] OFF_IOC = 5'h04;
  localparam logic [4:0] OFF_CNT = 5'h08;
  localparam logic [4:0] OFF_GRA = 5'h10;
  localparam logic [4:0] OFF_GR_STEP = 5'h04;
  localparam logic [7:0] OFF_PINCTL = 8'hA0;
  localparam logic [7:0] OFF_PINSTAT = 8'hA4;
  // control register fields
  localparam int CTL_RUN = 0;
  localparam int CTL_CLR = 1;
  localparam int CTL_PWM = 4;
  localparam int CTL_BUF = 6;
  localparam int CTL_TRANSFER_TIMING_SELECT_A = 7;
  localparam int CTL_CASC = 8;
  localparam int CTL_PHASE = 9;
  // io control: 4 bits per register, A in [3:0]
  localparam int IOC_INIT = 2;
  localparam int IOC_CAP = 3;
  localparam logic [1:0] ACT_LOW = 2'h1;
  localparam logic [1:0] ACT_HIGH = 2'h2;
  localparam logic [1:0] ACT_TOG = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  // capture_pin_control_reg bits
  localparam int PC_CH1_A = 0;
  localparam int PC_CH2_A = 2;
  // channel feature masks, bit n = channel n
  localparam logic [4:0] BUF_CH_MASK = 5'h19;
  localparam logic [4:0] CD_CH_MASK = 5'h19;
  localparam logic [4:0] PHASE_CH_MASK = 5'h06;
  localparam logic [4:0] INT_SRC_MASK = 5'h03;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] IOC_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] GR_RST = 16'hFFFF;
  localparam logic [3:0] PINCTL_RST = 4'h0;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    TBC_PWM_OFF = 2'h0,
    TBC_PWM_ONE = 2'h1,
    TBC_PWM_TWO = 2'h2
  } tbc_pwm_e;
endpackage

// >>> hw/tbc_top.sv
// Local design decisions: the register addresses and the Wishbone interface to the registers.
module tbc_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [19:0] pin_i,
  output logic [19:0] pin_o,
  output logic [19:0] pin_oe_o,
  input wire logic [3:0] ext_clk_i
);
  localparam int NCH = tbc_pkg::NUM_CH;

  logic [15:0] ctl_ff [NCH];
  logic [15:0] ioc_ff [NCH];
  logic [15:0] cnt_ff [NCH];
  logic [15:0] gr_ff [NCH][tbc_pkg::NUM_REG];
  logic [3:0] pinctl_ff;
  logic [3:0] ext_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic bus_req;
  logic wr_en;
  logic tick [NCH];
  logic up [NCH];
  logic ovf [NCH];
  logic unf [NCH];
  logic clr_evt [NCH];
  logic clr_xfer [NCH];
  logic cnt_wr [NCH];
  logic ioc_wr [NCH];
  logic match [NCH][tbc_pkg::NUM_REG];
  logic cap [NCH][tbc_pkg::NUM_REG];

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
                                        input logic [1:0] sel);
    merge = old;
    if (sel[0]) merge[7:0] = dat[7:0];
    if (sel[1]) merge[15:8] = dat[15:8];
  endfunction

  function automatic logic adr_hit(input logic [7:0] adr, input logic [2:0] ch,
                                   input logic [4:0] off);
    adr_hit = (adr == {ch, off});
  endfunction

  function automatic logic [3:0] io_field(input logic [15:0] ioc, input logic [1:0] r);
    io_field = ioc[4 * r +: 4];
  endfunction

  // ---------------- wishbone slave: one wait state, every address answers
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_en = bus_req & wb_we_i;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ack_ff <= 1'b0;
    end else if (ce_i) begin
      ack_ff <= bus_req;
    end
  end

  always_comb begin
    nxt_rdat = '0;
    for (int c = 0; c < NCH; c++) begin
      if (wb_adr_i[7:5] == 3'(c)) begin
        for (int r = 0; r < tbc_pkg::NUM_REG; r++) begin
          if (wb_adr_i[4:0] == 5'(tbc_pkg::OFF_GRA + tbc_pkg::OFF_GR_STEP * r) &&
              (r < 2 || tbc_pkg::CD_CH_MASK[c])) begin
            nxt_rdat[15:0] = gr_ff[c][r];
          end
        end
        case (wb_adr_i[4:0])
          tbc_pkg::OFF_CTL: nxt_rdat[15:0] = ctl_ff[c];
          tbc_pkg::OFF_IOC: nxt_rdat[15:0] = ioc_ff[c];
          tbc_pkg::OFF_CNT: nxt_rdat[15:0] = cnt_ff[c];
          default: ;
        endcase
      end
    end
    if (wb_adr_i == tbc_pkg::OFF_PINCTL) begin
      nxt_rdat[3:0] = pinctl_ff;
    end
    if (wb_adr_i == tbc_pkg::OFF_PINSTAT) begin
      nxt_rdat[19:0] = pin_o;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rdat_ff <= '0;
    end else if (ce_i && bus_req && !wb_we_i) begin
      rdat_ff <= nxt_rdat;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pinctl_ff <= tbc_pkg::PINCTL_RST;
    end else if (ce_i && wr_en && wb_adr_i == tbc_pkg::OFF_PINCTL && wb_sel_i[0]) begin
      pinctl_ff <= wb_dat_i[3:0];
    end
  end

  // encoder inputs are synchronous; one stage of history is enough for decode
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ext_ff <= 4'h0;
    end else if (ce_i) begin
      ext_ff <= ext_clk_i;
    end
  end

  // ---------------- channels
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    localparam bit HAS_CD = tbc_pkg::CD_CH_MASK[c];
    localparam int SRC = (c == 0) ? 1 : 0;
    logic run;
    logic phase;
    logic casc;
    logic pwm1;
    logic pwm2;
    logic buf_en;
    logic transfer_timing_select_a_eff;
    logic [2:0] clr_sel;
    logic has_period;
    logic [15:0] period_val;
    logic [15:0] cnt_wval;
    logic q_step;
    logic q_up;

    assign run = ctl_ff[c][tbc_pkg::CTL_RUN];
    assign phase = tbc_pkg::PHASE_CH_MASK[c] & ctl_ff[c][tbc_pkg::CTL_PHASE];
    assign casc = (c == 1) & ctl_ff[c][tbc_pkg::CTL_CASC] & ~phase; // RULE10
    assign pwm1 = ctl_ff[c][tbc_pkg::CTL_PWM +: 2] == tbc_pkg::TBC_PWM_ONE;
    assign pwm2 = (ctl_ff[c][tbc_pkg::CTL_PWM +: 2] == tbc_pkg::TBC_PWM_TWO) && c <= 2; // RULE23
    assign buf_en = tbc_pkg::BUF_CH_MASK[c] & ctl_ff[c][tbc_pkg::CTL_BUF];
    // elsewhere the bit is ignored and transfers stay on compare match
    assign transfer_timing_select_a_eff = ctl_ff[c][tbc_pkg::CTL_TRANSFER_TIMING_SELECT_A] &
                      ((c == 0 && (pwm1 || pwm2)) || ((c == 3 || c == 4) && pwm1)); // RULE2
    assign clr_sel = ctl_ff[c][tbc_pkg::CTL_CLR +: 3];
    assign has_period = clr_sel >= 3'h1 && clr_sel <= 3'h4;
    assign period_val = gr_ff[c][2'(clr_sel - 3'h1)]; // RULE15
    assign cnt_wval = merge(cnt_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]);
    assign cnt_wr[c] = wr_en && adr_hit(wb_adr_i, 3'(c), tbc_pkg::OFF_CNT);
    assign ioc_wr[c] = wr_en && adr_hit(wb_adr_i, 3'(c), tbc_pkg::OFF_IOC);

    if (c == 1 || c == 2) begin : g_ph
      localparam int P = 2 * (c - 1);
      // x4 quadrature: any phase edge steps, A against old B gives direction
      assign q_step = (ext_clk_i[P] ^ ext_ff[P]) | (ext_clk_i[P + 1] ^ ext_ff[P + 1]);
      assign q_up = ext_clk_i[P] ^ ext_ff[P + 1];
    end else begin : g_noph
      assign q_step = 1'b0;
      assign q_up = 1'b1;
    end

    always_comb begin
      if (phase) begin
        tick[c] = run & q_step;
        up[c] = q_up;
      end else if (casc) begin
        tick[c] = run & (ovf[2] | unf[2]); // RULE7 RULE8
        up[c] = ovf[2];
      end else begin
        tick[c] = run;
        up[c] = 1'b1;
      end
    end

    assign ovf[c] = tick[c] & up[c] & (cnt_ff[c] == tbc_pkg::CNT_MAX);
    // down counting only exists in phase mode or a cascaded upper half
    assign unf[c] = tick[c] & ~up[c] & (cnt_ff[c] == tbc_pkg::CNT_ZERO); // RULE9

    always_comb begin
      case (clr_sel)
        3'h1: clr_evt[c] = match[c][0] | cap[c][0];
        3'h2: clr_evt[c] = match[c][1] | cap[c][1];
        3'h3: clr_evt[c] = HAS_CD & (match[c][2] | cap[c][2]);
        3'h4: clr_evt[c] = HAS_CD & (match[c][3] | cap[c][3]);
        default: clr_evt[c] = 1'b0;
      endcase
    end

    assign clr_xfer[c] = ovf[c] | clr_evt[c] |
                         (cnt_wr[c] & run & (cnt_wval == tbc_pkg::CNT_ZERO)); // RULE4

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        ctl_ff[c] <= tbc_pkg::CTL_RST;
        ioc_ff[c] <= tbc_pkg::IOC_RST; // RULE3
      end else if (ce_i) begin
        if (wr_en && adr_hit(wb_adr_i, 3'(c), tbc_pkg::OFF_CTL)) begin
          ctl_ff[c] <= merge(ctl_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]);
        end
        if (ioc_wr[c]) begin
          ioc_ff[c] <= merge(ioc_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]);
        end
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
        cnt_ff[c] <= tbc_pkg::CNT_RST;
      end else if (ce_i) begin
        if (cnt_wr[c]) begin
          cnt_ff[c] <= cnt_wval;
        end else if (clr_evt[c]) begin
          cnt_ff[c] <= tbc_pkg::CNT_ZERO;
        end else if (tick[c]) begin
          cnt_ff[c] <= up[c] ? cnt_ff[c] + 16'h0001 : cnt_ff[c] - 16'h0001; // RULE8
        end
      end
    end

    for (genvar r = 0; r < tbc_pkg::NUM_REG; r++) begin : g_r
      localparam bit EXISTS = (r < 2) || HAS_CD;
      localparam int PART = r ^ 2;
      localparam int PA = r & 2;
      localparam int PB = r | 1;
      logic [3:0] f;
      logic [3:0] f_pair;
      logic [3:0] f_new;
      logic init_lvl;
      logic int_sel;
      logic add_pin;
      logic add_en;
      logic edge_hit;
      logic xfer;
      logic gr_wr;
      logic oe;
      tbc_pin_if pif ();

      assign f = io_field(ioc_ff[c], 2'(r));
      assign f_pair = io_field(ioc_ff[c], 2'(PB));
      // a write reloads the pin in its own cycle, so the level must come from the incoming value
      assign f_new = io_field(merge(ioc_ff[c], wb_dat_i[15:0], wb_sel_i[1:0]), 2'(r));
      assign init_lvl = ioc_wr[c] ? f_new[tbc_pkg::IOC_INIT] : f[tbc_pkg::IOC_INIT];
      assign int_sel = f[tbc_pkg::IOC_CAP] & f[tbc_pkg::IOC_INIT] & tbc_pkg::INT_SRC_MASK[c];

      if (c == 1 && r < 2) begin : g_x1
        assign add_pin = pin_i[tbc_pkg::PIN_PER_CH * 2 + r]; // RULE11
        assign add_en = pinctl_ff[tbc_pkg::PC_CH1_A + r] & ~int_sel; // RULE13
      end else if (c == 2 && r < 2) begin : g_x2
        assign add_pin = pin_i[tbc_pkg::PIN_PER_CH + r]; // RULE11
        assign add_en = pinctl_ff[tbc_pkg::PC_CH2_A + r] & ~int_sel; // RULE13
      end else begin : g_x0
        assign add_pin = 1'b0;
        assign add_en = 1'b0;
      end

      tbc_edge u_edge (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .own_i(pin_i[tbc_pkg::PIN_PER_CH * c + r]),
        .add_i(add_pin),
        .add_en_i(add_en),
        .edge_sel_i(f[1:0]),
        .hit_o(edge_hit)
      );

      assign match[c][r] = EXISTS && !f[tbc_pkg::IOC_CAP] && tick[c] &&
                           cnt_ff[c] == gr_ff[c][r];
      // an internal source replaces the pins entirely
      assign cap[c][r] = EXISTS && f[tbc_pkg::IOC_CAP] &&
                         (int_sel ? match[SRC][0] : edge_hit); // RULE13
      assign xfer = buf_en && r < 2 && !f[tbc_pkg::IOC_CAP] &&
                    (transfer_timing_select_a_eff ? clr_xfer[c] : match[c][r]); // RULE6
      assign gr_wr = wr_en && adr_hit(wb_adr_i, 3'(c),
                     5'(tbc_pkg::OFF_GRA + tbc_pkg::OFF_GR_STEP * r));

      // hardware transfers win over a software write in the same cycle
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          gr_ff[c][r] <= tbc_pkg::GR_RST;
        end else if (ce_i && EXISTS) begin
          if (r < 2 && cap[c][r]) begin
            gr_ff[c][r] <= cnt_ff[c];
          end else if (r >= 2 && buf_en && cap[c][PART]) begin
            gr_ff[c][r] <= gr_ff[c][PART]; // RULE1
          end else if (xfer) begin
            gr_ff[c][r] <= gr_ff[c][PART];
          end else if (r >= 2 && !buf_en && cap[c][r]) begin
            gr_ff[c][r] <= cnt_ff[c];
          end else if (gr_wr) begin
            gr_ff[c][r] <= merge(gr_ff[c][r], wb_dat_i[15:0], wb_sel_i[1:0]);
          end
        end
      end

      always_comb begin
        pif.load = ioc_wr[c];
        pif.init = init_lvl;
        pif.hit = 1'b0;
        pif.act = f[1:0];
        oe = 1'b0;
        if (pwm1) begin
          // B and D pins stay released, their matches steer A and C
          if ((r & 1) == 0) begin
            oe = EXISTS; // RULE16 RULE19
            pif.init = init_lvl; // RULE17
            if (gr_ff[c][PA] != gr_ff[c][PB]) begin // RULE18
              if (match[c][PA]) begin
                pif.hit = 1'b1;
              end else if (match[c][PB]) begin
                pif.hit = 1'b1;
                pif.act = f_pair[1:0]; // RULE16
              end
            end
          end
        end else if (pwm2) begin
          oe = EXISTS && !(has_period && clr_sel == 3'(r + 1)); // RULE20 RULE23 RULE24
          pif.load = ioc_wr[c] | clr_evt[c]; // RULE21
          pif.hit = match[c][r] && !(has_period && gr_ff[c][r] == period_val); // RULE22
        end else begin
          oe = EXISTS && !f[tbc_pkg::IOC_CAP] && f[1:0] != 2'h0;
          pif.hit = match[c][r]; // RULE14
        end
      end

      tbc_pin_out u_pin (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .p(pif.pin)
      );

      assign pin_o[tbc_pkg::PIN_PER_CH * c + r] = pif.level;
      assign pin_oe_o[tbc_pkg::PIN_PER_CH * c + r] = oe;
    end
  end

  // ---------------- checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cycle_clear;
    ce_i && g_ch[1].pwm2 && clr_evt[1] && !ioc_wr[1];
  endsequence

  sequence s_buf_capture;
    ce_i && g_ch[0].buf_en && cap[0][0];
  endsequence

  chk_cap_buffer: assert property ( // RULE1
    s_buf_capture |=> gr_ff[0][2] == $past(gr_ff[0][0]) && gr_ff[0][0] == $past(cnt_ff[0]))
    else $error("buffered capture did not shift A into C");
  chk_transfer_timing_select_a_gate: assert property ( // RULE2
    !g_ch[1].transfer_timing_select_a_eff && !g_ch[2].transfer_timing_select_a_eff)
    else $error("transfer timing select active on a channel without it");
  chk_match_xfer: assert property ( // RULE6
    ce_i && g_ch[0].buf_en && !g_ch[0].transfer_timing_select_a_eff && match[0][0] && !cap[0][0]
    |=> gr_ff[0][0] == $past(gr_ff[0][2]))
    else $error("compare match did not load A from C");
  chk_clear_xfer: assert property ( // RULE4
    ce_i && g_ch[0].g_r[0].xfer && g_ch[0].transfer_timing_select_a_eff && ovf[0] |=> gr_ff[0][0] == $past(gr_ff[0][2]))
    else $error("overflow did not transfer C into A");
  chk_cascade_step: assert property ( // RULE8
    ce_i && g_ch[1].casc && g_ch[1].run && ovf[2] && !cnt_wr[1] && !clr_evt[1]
    |=> cnt_ff[1] == $past(cnt_ff[1]) + 16'h0001)
    else $error("upper half missed a lower overflow");
  chk_under_phase: assert property ( // RULE9
    unf[2] |-> g_ch[2].phase)
    else $error("lower half underflowed outside phase mode");
  chk_phase_solo: assert property ( // RULE10
    g_ch[1].phase |-> !g_ch[1].casc && (tick[1] == (g_ch[1].run && g_ch[1].q_step)))
    else $error("channel 1 cascaded while in phase mode");
  chk_internal_src: assert property ( // RULE13
    g_ch[1].g_r[0].int_sel |-> !g_ch[1].g_r[0].add_en)
    else $error("added pin enabled under internal capture source");
  chk_pwm1_equal: assert property ( // RULE18
    ce_i && g_ch[0].pwm1 && gr_ff[0][0] == gr_ff[0][1] && !ioc_wr[0] |=> $stable(pin_o[0]))
    else $error("equal pair values changed the pin");
  chk_pwm2_restore: assert property ( // RULE21
    s_cycle_clear |=> pin_o[4] == $past(ioc_ff[1][tbc_pkg::IOC_INIT]))
    else $error("cycle clear did not restore initial level");
  chk_period_quiet: assert property ( // RULE23
    g_ch[1].pwm2 && ctl_ff[1][tbc_pkg::CTL_CLR +: 3] == 3'h2 |-> !pin_oe_o[5])
    else $error("period register pin driven in pwm2");
  chk_bus_ack: assert property (
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack lasted longer than one cycle");
endmodule

// >>> sim/tbc_pin_model.sv
module tbc_pin_model (
  input wire logic [19:0] pin_o_i,
  input wire logic [19:0] pin_oe_i,
  input wire logic [19:0] ext_i,
  output logic [19:0] pin_i_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // a driven pin reads back its own level, an undriven one the outside source
  assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_i);
endmodule

// >>> sim/timer_buffer_cascade_pwm_tb.sv
module timer_buffer_cascade_pwm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [19:0] ext = 20'h0;
  logic [3:0] qclk = 4'h0;
  logic [19:0] pin_i;
  logic [19:0] pin_o;
  logic [19:0] pin_oe;
  logic [15:0] rv;
  int failures = 0;
  int n_checks = 0;
  int cyc_cnt = 0;
  int hi;
  initial forever #2.5 clk = ~clk;
  tbc_top i_tbc_top (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe),
    .ext_clk_i(qclk));
  tbc_pin_model i_tbc_pin_model (.pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_i(ext),
    .pin_i_o(pin_i));
  task final_report;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      failures++;
      final_report;
    end
  end
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {16'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    rv = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) chk("ack", 32'h0, 32'h1);
  endtask
  task rc(input string what, input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(what, {16'h0, rv}, {16'h0, e});
  endtask
  task pulse(input int k);
    @(posedge clk);
    ext[k] <= 1'b1;
    repeat (3) @(posedge clk);
    ext[k] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task qstep(input logic [1:0] v);
    @(posedge clk);
    qclk[3:2] <= v;
    repeat (3) @(posedge clk);
  endtask
  task count_hi(input int k, input int n);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      hi += int'(pin_o[k]);
    end
  endtask
  task t_reset;
    rc("ctl0", 8'h00, 16'h0000);
    rc("gra0", 8'h10, 16'hFFFF);
    rc("pinctl", 8'hA0, 16'h0000);
    bus(1'b1, 8'hC0, 16'h1234);
    rc("unmapped", 8'hC0, 16'h0000);
    chk("pin_oe", {12'h0, pin_oe}, 32'h0);
    $display("test reset done");
  endtask
  task t_bufcap;
    bus(1'b1, 8'h04, 16'h0008);
    bus(1'b1, 8'h00, 16'h0040);
    bus(1'b1, 8'h08, 16'h1234);
    bus(1'b1, 8'h10, 16'h0055);
    pulse(0);
    rc("gra0 cap", 8'h10, 16'h1234);
    rc("grc0 old", 8'h18, 16'h0055);
    $display("test buffered capture done");
  endtask
  task t_cross;
    bus(1'b1, 8'h24, 16'h0008);
    bus(1'b1, 8'h28, 16'h0AAA);
    pulse(8);
    rc("gra1 off", 8'h30, 16'hFFFF);
    bus(1'b1, 8'hA0, 16'h0001);
    pulse(8);
    rc("gra1 added", 8'h30, 16'h0AAA);
    bus(1'b1, 8'h28, 16'h0BBB);
    pulse(4);
    rc("gra1 own", 8'h30, 16'h0BBB);
    bus(1'b1, 8'h24, 16'h000C);
    bus(1'b1, 8'h28, 16'h0CCC);
    pulse(8);
    rc("gra1 internal", 8'h30, 16'h0BBB);
    bus(1'b1, 8'h44, 16'h0008);
    bus(1'b1, 8'hA0, 16'h0004);
    bus(1'b1, 8'h48, 16'h0DDD);
    pulse(4);
    rc("gra2 added", 8'h50, 16'h0DDD);
    $display("test cross capture done");
  endtask
  task t_cascade;
    bus(1'b1, 8'h48, 16'hFFFE);
    bus(1'b1, 8'h28, 16'h0005);
    bus(1'b1, 8'h20, 16'h0101);
    bus(1'b1, 8'h40, 16'h0001);
    repeat (10) @(posedge clk);
    bus(1'b1, 8'h40, 16'h0000);
    bus(1'b1, 8'h20, 16'h0000);
    rc("cnt1 upper", 8'h28, 16'h0006);
    bus(1'b0, 8'h48, 16'h0000);
    chk("cnt2 lower", {31'h0, rv < 16'h0020}, 32'h1);
    $display("test cascade done");
  endtask
  task t_pwm1;
    bus(1'b1, 8'h00, 16'h0012);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h10, 16'h0010);
    bus(1'b1, 8'h14, 16'h0008);
    bus(1'b1, 8'h04, 16'h0025);
    repeat (2) @(posedge clk);
    chk("init high", {31'h0, pin_o[0]}, 32'h1);
    bus(1'b1, 8'h04, 16'h0021);
    repeat (2) @(posedge clk);
    chk("init low", {31'h0, pin_o[0]}, 32'h0);
    bus(1'b1, 8'h00, 16'h0013);
    count_hi(0, 68);
    chk("pwm1 duty", {31'h0, hi >= 28 && hi <= 36}, 32'h1);
    chk("pwm1 oe", {31'h0, pin_oe[0]}, 32'h1);
    bus(1'b1, 8'h00, 16'h0012);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h14, 16'h0010);
    bus(1'b1, 8'h04, 16'h0012);
    bus(1'b1, 8'h00, 16'h0013);
    count_hi(0, 40);
    chk("pwm1 equal", hi, 32'h0);
    bus(1'b1, 8'h00, 16'h0012);
    $display("test pwm1 done");
  endtask
  task t_pwm2;
    bus(1'b1, 8'h28, 16'h0000);
    bus(1'b1, 8'h34, 16'h000C);
    bus(1'b1, 8'h30, 16'h0004);
    bus(1'b1, 8'h24, 16'h0022);
    bus(1'b1, 8'h20, 16'h0025);
    count_hi(4, 65);
    chk("pwm2 duty", {31'h0, hi >= 36 && hi <= 48}, 32'h1);
    chk("period pin", {31'h0, pin_oe[5]}, 32'h0);
    bus(1'b1, 8'h20, 16'h0024);
    bus(1'b1, 8'h28, 16'h0000);
    bus(1'b1, 8'h30, 16'h000C);
    bus(1'b1, 8'h24, 16'h0022);
    bus(1'b1, 8'h20, 16'h0025);
    count_hi(4, 40);
    chk("pwm2 equal", hi, 32'h0);
    bus(1'b1, 8'h20, 16'h0024);
    $display("test pwm2 done");
  endtask
  task t_phase;
    bus(1'b1, 8'h48, 16'h0000);
    bus(1'b1, 8'h28, 16'h0005);
    bus(1'b1, 8'h20, 16'h0101);
    bus(1'b1, 8'h40, 16'h0201);
    qstep(2'h2);
    rc("cnt2 under", 8'h48, 16'hFFFF);
    rc("cnt1 down", 8'h28, 16'h0004);
    qstep(2'h0);
    rc("cnt1 up", 8'h28, 16'h0005);
    bus(1'b1, 8'h20, 16'h0301);
    qstep(2'h2);
    rc("cnt1 solo", 8'h28, 16'h0005);
    bus(1'b1, 8'h40, 16'h0000);
    bus(1'b1, 8'h20, 16'h0000);
    $display("test phase cascade done");
  endtask
  task t_buftime;
    bus(1'b1, 8'h04, 16'h0000);
    bus(1'b1, 8'h00, 16'h0054);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h10, 16'h0003);
    bus(1'b1, 8'h14, 16'h0020);
    bus(1'b1, 8'h18, 16'h0007);
    bus(1'b1, 8'h00, 16'h0055);
    repeat (10) @(posedge clk);
    bus(1'b1, 8'h00, 16'h0054);
    rc("match transfer", 8'h10, 16'h0007);
    bus(1'b1, 8'h00, 16'h00D4);
    bus(1'b1, 8'h08, 16'h0000);
    bus(1'b1, 8'h10, 16'h0003);
    bus(1'b1, 8'h00, 16'h00D5);
    repeat (10) @(posedge clk);
    rc("no match transfer", 8'h10, 16'h0003);
    bus(1'b1, 8'h08, 16'h0000);
    rc("zero write transfer", 8'h10, 16'h0007);
    bus(1'b1, 8'h00, 16'h00D4);
    bus(1'b1, 8'h10, 16'h0003);
    bus(1'b1, 8'h18, 16'h0009);
    bus(1'b1, 8'h08, 16'hFFF8);
    bus(1'b1, 8'h00, 16'h00D5);
    repeat (20) @(posedge clk);
    rc("wrap transfer", 8'h10, 16'h0009);
    bus(1'b1, 8'h00, 16'h00D4);
    $display("test transfer timing done");
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_bufcap;
    t_cross;
    t_cascade;
    t_pwm1;
    t_pwm2;
    t_phase;
    t_buftime;
    final_report;
  end
endmodule
